// [design/scp_defines.svh]
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ==========================================================
// register offsets
`define SCP_OFF_ADDR      8'h00
`define SCP_OFF_RESET     8'h01
`define SCP_OFF_GCFG      8'h02

// ==========================================================
// field positions
`define SCP_ADDR_SRC_BIT  0
`define SCP_BACK_LINK_BIT 2
`define SCP_FULL_RST_BIT  1
`define SCP_PART_RST_BIT  0
`define SCP_G_DRIVE_EN    7
`define SCP_G_OVERRIDE    6
`define SCP_G_OSC_CLK     5
`define SCP_G_SLEEP_SEL   4
`define SCP_G_LEGACY_SRC  3
`define SCP_G_LEGACY      2
`define SCP_G_LOWF_SRC    1
`define SCP_G_LOWF        0

// ==========================================================
// reset values
`define SCP_RESET_RST     8'h04
`define SCP_GCFG_RST      8'h00

// ==========================================================
// strap band to bus address
`define SCP_STRAP_BAND0   7'h2C
`define SCP_STRAP_BASE    7'h32
`define SCP_STRAP_TOP     7'h3B
`define SCP_STRAP_BANDS   4'hA

// ==========================================================
// timing: cycles after reset before the strap is caught
`define SCP_STRAP_SETTLE  3'h7

`endif

// [design/scp_pkg.sv]
package scp_pkg;

   // ==========================================================
   // bus engine states
   typedef enum logic [6:0] {
      SCP_IDLE     = 7'h01,
      SCP_ADDR     = 7'h02,
      SCP_ADDR_ACK = 7'h04,
      SCP_WR_BYTE  = 7'h08,
      SCP_WR_ACK   = 7'h10,
      SCP_RD_BYTE  = 7'h20,
      SCP_RD_ACK   = 7'h40
   } scp_fsm_t;

   // ==========================================================
   // whole module state
   typedef struct packed {
      scp_fsm_t    fsm;
      logic [10:0] s1;
      logic [10:0] s2;
      logic [10:0] s3;
      logic [10:0] filt;
      logic        scl_prev;
      logic        sda_prev;
      logic        lock_prev;
      logic [7:0]  shreg;
      logic [7:0]  tx;
      logic [3:0]  cnt;
      logic        rw;
      logic        first;
      logic [7:0]  offset;
      logic [6:0]  own_addr;
      logic        addr_src;
      logic [6:0]  strap_addr;
      logic [2:0]  strap_cnt;
      logic        strap_ok;
      logic        back_link;
      logic [7:0]  gcfg;
      logic        full_pend;
      logic        part_pend;
      logic        sda_oe_n;
      logic        sda_out;
      logic        drive_en;
      logic        sleep_sel;
      logic        osc_sel;
      logic        legacy;
      logic        low_freq;
      logic        full_pulse;
      logic        part_pulse;
   } scp_state_t;

endpackage

// [design/scp_serial_config_port.sv]
// Function
// - answers one of ten selectable addresses
// - strap band maps to 0x2C or 0x33-0x3B
// - start, repeated start and stop frame transfers
// - matching address is acknowledged with data low
// - mismatching address leaves data line released
// - every written byte is acknowledged
// - exchanges open with start, close with stop
// - lines only pulled low or released
// - address field writable only while bit0 set
// - bit0 picks strap or register address
// - bit1 resets all logic and registers except the input sync
// - bit0 resets logic but not registers
// - output enable bit, cleared on lock loss
// - bit6 lets register bits override pins
// - bit5 sends oscillator clock when unlocked
// - bit4 picks tristate or sleep state
// - bit3 picks legacy mode source
// - bit2 sets legacy mode when selected
// - bit1 picks low freq source, bit0 value
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_serial_config_port (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic [3:0] address_strap_pin,
   input  wire logic       link_lock,
   input  wire logic       legacy_compat_pin,
   input  wire logic       low_freq_range_pin,
   input  wire logic       lvcmos_drive_enable_pin,
   input  wire logic       sleep_state_select_pin,
   output logic            lvcmos_drive_enable,
   output logic            sleep_state_select,
   output logic            lvds_clock_out_osc_sel,
   output logic            legacy_compat,
   output logic            low_freq_range,
   output logic            back_link_enable,
   output logic            full_digital_reset,
   output logic            partial_digital_reset
);

   // ==========================================================
   // reset image
   localparam scp_pkg::scp_state_t SCP_RST = '{
      fsm:       scp_pkg::SCP_IDLE,
      // bus lines idle high in every stage, so no false edge after reset
      s1:        11'h003,
      s2:        11'h003,
      s3:        11'h003,
      filt:      11'h003,
      scl_prev:  1'b1,
      sda_prev:  1'b1,
      back_link: 1'b1,
      gcfg:      `SCP_GCFG_RST,
      sda_oe_n:  1'b1,
      default:   '0
   };

   scp_pkg::scp_state_t q;
   scp_pkg::scp_state_t d;

   logic       scl;
   logic       sda;
   logic       lock;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       lock_fall;
   logic [6:0] eff_addr;
   logic [7:0] rd_data;

   // ==========================================================
   // helpers
   // strap band decode
   function automatic logic [6:0] scp_strap_map(input logic [3:0] band);
      if (band == 4'h0) begin
         scp_strap_map = `SCP_STRAP_BAND0;
      end else if (band < `SCP_STRAP_BANDS) begin
         scp_strap_map = `SCP_STRAP_BASE + {3'h0, band};
      end else begin
         scp_strap_map = `SCP_STRAP_TOP;
      end
   endfunction

   // register read mux, unlisted offsets read zero
   function automatic logic [7:0] scp_read(
      input logic [7:0]          off,
      input scp_pkg::scp_state_t s,
      input logic [6:0]          addr
   );
      case (off)
         `SCP_OFF_ADDR:  scp_read = {addr, s.addr_src};
         `SCP_OFF_RESET: scp_read = {5'h00, s.back_link, 2'h0};
         `SCP_OFF_GCFG:  scp_read = s.gcfg;
         default:        scp_read = 8'h00;
      endcase
   endfunction

   assign scl       = q.filt[0];
   assign sda       = q.filt[1];
   assign lock      = q.filt[2];
   assign scl_rise  = scl & ~q.scl_prev;
   assign scl_fall  = ~scl & q.scl_prev;
   // frame conditions with the clock held high
   assign start_det = scl & q.scl_prev & q.sda_prev & ~sda;
   assign stop_det  = scl & q.scl_prev & ~q.sda_prev & sda;
   assign lock_fall = q.lock_prev & ~lock;
   assign eff_addr  = q.addr_src ? q.own_addr : q.strap_addr;
   assign rd_data   = scp_read(q.offset, q, eff_addr);

   // ==========================================================
   // next state
   always_comb begin
      d            = q;
      d.full_pulse = 1'b0;
      d.part_pulse = 1'b0;
      d.sda_out    = 1'b0;
      // three-stage sync; s1 feeds only s2
      d.s1 = {address_strap_pin, sleep_state_select_pin,
              lvcmos_drive_enable_pin, low_freq_range_pin,
              legacy_compat_pin, link_lock, sda_in, scl_in};
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < 11; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.filt[i] = q.s3[i];
         end
      end
      d.scl_prev  = scl;
      d.sda_prev  = sda;
      d.lock_prev = lock;

      // strap caught once the sync has settled
      if (!q.strap_ok) begin
         d.strap_cnt = q.strap_cnt + 3'h1;
         if (q.strap_cnt == `SCP_STRAP_SETTLE) begin
            d.strap_ok   = 1'b1;
            d.strap_addr = scp_strap_map(q.filt[10:7]);
            d.own_addr   = scp_strap_map(q.filt[10:7]);
         end
      end

      case (q.fsm)
         scp_pkg::SCP_IDLE: begin
            d.sda_oe_n = 1'b1;
         end
         scp_pkg::SCP_ADDR: begin
            if (scl_rise) begin
               d.shreg = {q.shreg[6:0], sda};
               d.cnt   = q.cnt + 4'h1;
            end else if (scl_fall && q.cnt == 4'h8) begin
               if (q.strap_ok && q.shreg[7:1] == eff_addr) begin
                  d.sda_oe_n = 1'b0;
                  d.rw       = q.shreg[0];
                  d.fsm      = scp_pkg::SCP_ADDR_ACK;
               end else begin
                  // release, stay quiet until next start
                  d.sda_oe_n = 1'b1;
                  d.fsm      = scp_pkg::SCP_IDLE;
               end
            end
         end
         scp_pkg::SCP_ADDR_ACK, scp_pkg::SCP_RD_ACK: begin
            if (q.fsm == scp_pkg::SCP_RD_ACK && scl_rise && sda) begin
               d.fsm = scp_pkg::SCP_IDLE;
            end else if (scl_fall) begin
               d.cnt = 4'h0;
               if (q.rw) begin
                  d.sda_oe_n = rd_data[7];
                  d.tx       = {rd_data[6:0], 1'b0};
                  d.fsm      = scp_pkg::SCP_RD_BYTE;
               end else begin
                  d.sda_oe_n = 1'b1;
                  d.fsm      = scp_pkg::SCP_WR_BYTE;
               end
            end
         end
         scp_pkg::SCP_WR_BYTE: begin
            if (scl_rise) begin
               d.shreg = {q.shreg[6:0], sda};
               d.cnt   = q.cnt + 4'h1;
            end else if (scl_fall && q.cnt == 4'h8) begin
               d.sda_oe_n = 1'b0;
               d.fsm      = scp_pkg::SCP_WR_ACK;
               if (q.first) begin
                  // first data byte is the offset
                  d.first  = 1'b0;
                  d.offset = q.shreg;
               end else begin
                  case (q.offset)
                     `SCP_OFF_ADDR: begin
                        // field locked unless bit0 stored set
                        if (q.addr_src) begin
                           d.own_addr = q.shreg[7:1];
                        end
                        d.addr_src = q.shreg[`SCP_ADDR_SRC_BIT];
                     end
                     `SCP_OFF_RESET: begin
                        d.back_link = q.shreg[`SCP_BACK_LINK_BIT];
                        // full reset taken at the stop
                        if (q.shreg[`SCP_FULL_RST_BIT]) begin
                           d.full_pend = 1'b1;
                        end
                        // partial reset taken at the stop
                        if (q.shreg[`SCP_PART_RST_BIT]) begin
                           d.part_pend = 1'b1;
                        end
                     end
                     `SCP_OFF_GCFG: begin
                        d.gcfg = q.shreg;
                     end
                     default: begin
                        d.gcfg = q.gcfg;
                     end
                  endcase
               end
            end
         end
         scp_pkg::SCP_WR_ACK: begin
            if (scl_fall) begin
               d.sda_oe_n = 1'b1;
               d.cnt      = 4'h0;
               d.fsm      = scp_pkg::SCP_WR_BYTE;
            end
         end
         scp_pkg::SCP_RD_BYTE: begin
            if (scl_rise) begin
               d.cnt = q.cnt + 4'h1;
            end else if (scl_fall) begin
               if (q.cnt == 4'h8) begin
                  d.sda_oe_n = 1'b1;
                  d.fsm      = scp_pkg::SCP_RD_ACK;
               end else begin
                  // a one bit is a released line
                  d.sda_oe_n = q.tx[7];
                  d.tx       = {q.tx[6:0], 1'b0};
               end
            end
         end
         default: begin
            d.fsm      = scp_pkg::SCP_IDLE;
            d.sda_oe_n = 1'b1;
         end
      endcase

      if (start_det) begin
         d.fsm      = scp_pkg::SCP_ADDR;
         d.cnt      = 4'h0;
         d.first    = 1'b1;
         d.sda_oe_n = 1'b1;
      end

      // losing lock beats a same-cycle write
      if (lock_fall) begin
         d.gcfg[`SCP_G_DRIVE_EN] = 1'b0;
      end

      // override picks register or pin control
      if (q.gcfg[`SCP_G_OVERRIDE]) begin
         d.drive_en  = lock & q.gcfg[`SCP_G_DRIVE_EN];
         d.sleep_sel = q.gcfg[`SCP_G_SLEEP_SEL];
      end else begin
         d.drive_en  = lock & q.filt[5];
         d.sleep_sel = q.filt[6];
      end
      d.osc_sel  = q.gcfg[`SCP_G_OSC_CLK] & ~lock;
      d.legacy   = q.gcfg[`SCP_G_LEGACY_SRC] ?
                   q.gcfg[`SCP_G_LEGACY] : q.filt[3];
      d.low_freq = q.gcfg[`SCP_G_LOWF_SRC] ?
                   q.gcfg[`SCP_G_LOWF] : q.filt[4];

      if (stop_det) begin
         d.fsm      = scp_pkg::SCP_IDLE;
         d.sda_oe_n = 1'b1;
         if (q.part_pend) begin
            d.part_pend  = 1'b0;
            d.part_pulse = 1'b1;
         end
      end

      if (!rst_n) begin
         d = SCP_RST;
      end else if (stop_det && q.full_pend) begin
         // defaults back, strap caught again; sync kept
         d            = SCP_RST;
         d.s1         = q.s1;
         d.s2         = q.s2;
         d.s3         = q.s3;
         d.filt       = q.filt;
         d.full_pulse = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      q <= d;
   end

   assign sda_out                = q.sda_out;
   assign sda_oe_n               = q.sda_oe_n;
   assign lvcmos_drive_enable    = q.drive_en;
   assign sleep_state_select     = q.sleep_sel;
   assign lvds_clock_out_osc_sel = q.osc_sel;
   assign legacy_compat          = q.legacy;
   assign low_freq_range         = q.low_freq;
   assign back_link_enable       = q.back_link;
   assign full_digital_reset     = q.full_pulse;
   assign partial_digital_reset  = q.part_pulse;

   // ==========================================================
   // checks
   sequence s_addr_done;
      q.fsm == scp_pkg::SCP_ADDR && scl_fall && q.cnt == 4'h8;
   endsequence

   sequence s_wr_done;
      q.fsm == scp_pkg::SCP_WR_BYTE && scl_fall && q.cnt == 4'h8 &&
      !start_det && !stop_det;
   endsequence

   AST_ADDR_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_addr_done and (q.strap_ok && q.shreg[7:1] == eff_addr &&
      !start_det && !stop_det) |=> !sda_oe_n)
      else $error("matching address not acknowledged");

   AST_ADDR_NACK: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_addr_done and (q.shreg[7:1] != eff_addr) |=>
      sda_oe_n && q.fsm == scp_pkg::SCP_IDLE)
      else $error("foreign address touched the data line");

   AST_WR_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_wr_done |=> !sda_oe_n ##1 !sda_oe_n)
      else $error("written byte not acknowledged");

   AST_STOP_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
      stop_det |=> q.fsm == scp_pkg::SCP_IDLE && sda_oe_n)
      else $error("stop did not end the transfer");

   AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (!rst_n)
      !sda_out)
      else $error("data line driven high");

   AST_ADDR_LOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_wr_done and (!q.first && q.offset == `SCP_OFF_ADDR &&
      !q.addr_src) |=> $stable(q.own_addr))
      else $error("address field written while locked");

   AST_FULL_RST: assert property (@(posedge core_clk) disable iff (!rst_n)
      stop_det && q.full_pend |=> full_digital_reset &&
      q.gcfg == `SCP_GCFG_RST && back_link_enable ##1
      !full_digital_reset)
      else $error("full reset not a one-cycle default reload");

   AST_PART_RST: assert property (@(posedge core_clk) disable iff (!rst_n)
      stop_det && q.part_pend && !q.full_pend |=>
      partial_digital_reset && $stable(q.gcfg) ##1
      !partial_digital_reset)
      else $error("partial reset misbehaved");

   AST_LOCK_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
      lock_fall |=> !q.gcfg[`SCP_G_DRIVE_EN] ##1 !lvcmos_drive_enable)
      else $error("output enable survived lock loss");

   AST_OSC_CLK: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.gcfg[`SCP_G_OSC_CLK] && !lock)[*2] |-> lvds_clock_out_osc_sel)
      else $error("oscillator clock not selected while unlocked");

   AST_LEGACY: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.gcfg[`SCP_G_LEGACY_SRC] ##1 q.gcfg[`SCP_G_LEGACY_SRC] |->
      legacy_compat == $past(q.gcfg[`SCP_G_LEGACY]))
      else $error("legacy mode ignores register value");

endmodule

// [tb/scp_i2c_host.sv]
`timescale 1ns/1ps

module scp_i2c_host (
   input  wire logic core_clk,
   input  wire logic sda,
   input  wire logic scl_wire,
   output logic      scl,
   output logic      sda_oe_n
);

   // ==========================================================
   // idle bus: data line released to the pull-up, clock driven high
   // data line only pulled low or released; clock driven high and low
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // ==========================================================
   // framing
   // start or repeated start
   task automatic start();
      sda_oe_n <= 1'b1;
      wait_clk(4);
      scl <= 1'b1;
      wait_clk(8);
      sda_oe_n <= 1'b0;
      wait_clk(8);
      scl <= 1'b0;
      wait_clk(4);
   endtask

   // stop, data rises while clock high
   task automatic stop();
      sda_oe_n <= 1'b0;
      wait_clk(4);
      scl <= 1'b1;
      wait_clk(8);
      sda_oe_n <= 1'b1;
      wait_clk(8);
   endtask

   // ==========================================================
   // bit and byte
   task automatic put_bit(input logic b, output logic r);
      sda_oe_n <= b;
      wait_clk(4);
      scl <= 1'b1;
      // waits out a held clock, bounded
      for (int i = 0; i < 64 && scl_wire !== 1'b1; i++) wait_clk(1);
      // the loop above always spends one cycle: 8 high, 8 low, 160 ns
      wait_clk(3);
      r = sda;
      wait_clk(4);
      scl <= 1'b0;
      wait_clk(4);
   endtask

   // ack_in low asks for more, high ends a read
   task automatic xfer(input  logic [7:0] tx,
                       input  logic       ack_in,
                       output logic [7:0] rx,
                       output logic       ack);
      for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
      put_bit(ack_in, ack);
   endtask

endmodule

// [tb/tb_serial_config_port.sv]
`timescale 1ns/1ps

module tb_serial_config_port;

   // ==========================================================
   // signals
   logic        core_clk;
   logic        rst_n;
   logic        host_scl;
   logic        host_oe_n;
   logic        dut_oe_n;
   logic        dut_sda;
   logic [3:0]  strap;
   logic        link_lock;
   logic        leg_pin;
   logic        lf_pin;
   logic        de_pin;
   logic        ss_pin;
   logic        drive_en;
   logic        sleep_sel;
   logic        osc_sel;
   logic        legacy;
   logic        lowf;
   logic        back_link;
   logic        full_rst;
   logic        part_rst;
   logic [31:0] seed;
   logic [31:0] r;
   logic [7:0]  g;
   logic [6:0]  dev;
   logic        ack;
   int          fails;
   int          comparisons;
   int          nfull;
   int          npart;
   wire         sda_w = host_oe_n & (dut_oe_n | dut_sda);

   scp_serial_config_port DUT (
      .core_clk(core_clk), .rst_n(rst_n), .scl_in(host_scl),
      .sda_in(sda_w), .sda_out(dut_sda), .sda_oe_n(dut_oe_n),
      .address_strap_pin(strap), .link_lock(link_lock),
      .legacy_compat_pin(leg_pin), .low_freq_range_pin(lf_pin),
      .lvcmos_drive_enable_pin(de_pin), .sleep_state_select_pin(ss_pin),
      .lvcmos_drive_enable(drive_en), .sleep_state_select(sleep_sel),
      .lvds_clock_out_osc_sel(osc_sel), .legacy_compat(legacy),
      .low_freq_range(lowf), .back_link_enable(back_link),
      .full_digital_reset(full_rst), .partial_digital_reset(part_rst)
   );

   scp_i2c_host u_host (
      .core_clk(core_clk), .sda(sda_w), .scl_wire(host_scl),
      .scl(host_scl), .sda_oe_n(host_oe_n)
   );

   // ==========================================================
   // helpers
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [6:0] strap_addr(input logic [3:0] b);
      if (b == 4'h0) return 7'h2C;
      if (b >= 4'hA) return 7'h3B;
      return 7'h32 + {3'h0, b};
   endfunction

   function logic [7:0] exp_out(input logic [7:0] v);
      return {3'h0, link_lock & (v[6] ? v[7] : de_pin),
              v[6] ? v[4] : ss_pin, v[5] & ~link_lock,
              v[3] ? v[2] : leg_pin, v[1] ? v[0] : lf_pin};
   endfunction

   function logic [7:0] got_out();
      return {3'h0, drive_en, sleep_sel, osc_sel, legacy, lowf};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==========================================================
   // bus transactions
   task automatic frame(input logic [6:0] a, input logic rw,
                        output logic a_ack);
      logic [7:0] rx;
      u_host.start();
      u_host.xfer({a, rw}, 1'b1, rx, a_ack);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] off,
                     input logic [7:0] d);
      logic       k;
      logic [7:0] rx;
      frame(a, 1'b0, k);
      check({7'h0, k}, 8'h00);
      u_host.xfer(off, 1'b1, rx, k);
      check({7'h0, k}, 8'h00);
      u_host.xfer(d, 1'b1, rx, k);
      check({7'h0, k}, 8'h00);
      u_host.stop();
      u_host.wait_clk(12);
   endtask

   task automatic rdchk(input logic [6:0] a, input logic [7:0] off,
                        input logic [7:0] exp, input int n);
      logic       k;
      logic [7:0] rx;
      frame(a, 1'b0, k);
      u_host.xfer(off, 1'b1, rx, k);
      frame(a, 1'b1, k);
      check({7'h0, k}, 8'h00);
      for (int i = 0; i < n; i++) begin
         u_host.xfer(8'hFF, i == n - 1, rx, k);
         check(rx, exp);
      end
      u_host.stop();
   endtask

   // ==========================================================
   // clock, pulse counters, watchdog
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (full_rst === 1'b1) nfull++;
      if (part_rst === 1'b1) npart++;
   end

   // traffic takes about 20000 cycles; 50000 leaves margin
   initial begin
      #500000;
      fails++;
      finish_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      fails = 0;
      comparisons = 0;
      nfull = 0;
      npart = 0;
      seed = 32'h0000455E;
      r = rnd();
      rst_n = 1'b0;
      strap = r[3:0] % 4'hA;
      link_lock = 1'b1;
      {leg_pin, lf_pin, de_pin, ss_pin} = r[7:4];
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      u_host.wait_clk(20);
      dev = strap_addr(strap);
      check(got_out(), exp_out(8'h00));
      check({7'h0, back_link}, 8'h01);
      rdchk(dev, 8'h00, {dev, 1'b0}, 1);
      rdchk(dev, 8'h01, 8'h04, 1);
      rdchk(dev, 8'h02, 8'h00, 3);
      frame(dev ^ 7'h01, 1'b0, ack);
      u_host.stop();
      check({7'h0, ack}, 8'h01);
      // random settings, corners first
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         g = (k == 0) ? 8'hFF : (k == 1) ? 8'h40 : r[7:0];
         @(posedge core_clk);
         {leg_pin, lf_pin, de_pin, ss_pin} <= r[11:8];
         wr(dev, 8'h02, g);
         check(got_out(), exp_out(g));
         rdchk(dev, 8'h02, g, 1);
      end
      // loss of lock clears the drive enable
      wr(dev, 8'h02, 8'hE1);
      link_lock <= 1'b0;
      u_host.wait_clk(12);
      check(got_out(), exp_out(8'h61));
      rdchk(dev, 8'h02, 8'h61, 1);
      link_lock <= 1'b1;
      // address field gated by the stored source bit
      wr(dev, 8'h00, 8'h51);
      rdchk(dev, 8'h00, {dev, 1'b1}, 1);
      wr(dev, 8'h00, 8'h51);
      rdchk(7'h28, 8'h00, 8'h51, 1);
      frame(dev, 1'b0, ack);
      u_host.stop();
      check({7'h0, ack}, 8'h01);
      // partial reset keeps registers
      // reserved reset bits written as zero
      wr(7'h28, 8'h01, 8'h01);
      check(npart[7:0], 8'h01);
      check({7'h0, back_link}, 8'h00);
      rdchk(7'h28, 8'h01, 8'h00, 1);
      rdchk(7'h28, 8'h02, 8'h61, 1);
      wr(7'h28, 8'h05, 8'hA5);
      rdchk(7'h28, 8'h05, 8'h00, 1);
      // full reset restores defaults and the strap address
      wr(7'h28, 8'h01, 8'h02);
      u_host.wait_clk(30);
      check(nfull[7:0], 8'h01);
      check({7'h0, back_link}, 8'h01);
      rdchk(dev, 8'h00, {dev, 1'b0}, 1);
      rdchk(dev, 8'h02, 8'h00, 1);
      rdchk(dev, 8'h01, 8'h04, 1);
      finish_test();
   end

endmodule
